// ===== core/fcp_pkg.sv
// constants, register map and field layout of the five-channel pwm unit
package fcp_pkg;
	localparam int          FCP_CHANNELS       = 5;
	localparam int          FCP_DATA_W         = 8;
	localparam logic [7:0]  FCP_COUNT_LAST     = 8'hFE;
	localparam logic [7:0]  FCP_BYTE_RESET     = 8'h00;
	localparam logic [9:0]  FCP_IDX_CTRL_TWO   = 10'h0CE;
	localparam logic [11:0] FCP_ADDR_PRESCALE  = 12'h000;
	localparam logic [11:0] FCP_ADDR_CTRL_ONE  = 12'h004;
	localparam logic [11:0] FCP_ADDR_DUTY_BASE = 12'h008;
	localparam logic [11:0] FCP_ADDR_STATUS    = 12'h01C;
	localparam logic [11:0] FCP_ADDR_CTRL_TWO  = {FCP_IDX_CTRL_TWO, 2'h0};
	localparam int          FCP_CTRL_ONE_OE_LSB = 4;
	localparam int          FCP_CTRL_TWO_EN_BIT = 0;
	localparam int          FCP_CTRL_TWO_OE_BIT = 2;
	localparam logic [7:0]  FCP_CTRL_TWO_MASK  = 8'h05;
	localparam logic [1:0]  FCP_HRESP_OKAY     = 2'h0;
endpackage : fcp_pkg

// ===== core/fcp_tb_if.sv
// shared counter value passed from the timebase to the channels
`timescale 1ns/10ps
interface fcp_tb_if
	#(parameter int W = 8);
	logic [W-1:0] count;
	modport src (output count);
	modport snk (input count);
endinterface : fcp_tb_if

// ===== core/fcp_timebase.sv
// shared prescaler and modulo-255 counter
`timescale 1ns/10ps
module fcp_timebase
	import fcp_pkg::*;
	#(parameter int W = FCP_DATA_W)
(
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic [W-1:0] prescale,
	fcp_tb_if.src             tb
);
	logic [W-1:0] div_reg;
	logic [W-1:0] div_next;
	logic         half_reg;
	logic         half_next;
	logic [W-1:0] count_reg;
	logic [W-1:0] count_next;

	// a shrinking prescale value ends the current interval at once rather than wrapping
	always_comb
	begin
		div_next   = div_reg;
		half_next  = half_reg;
		count_next = count_reg;
		if (div_reg >= prescale)
		begin
			div_next  = '0;
			half_next = ~half_reg;
			if (half_reg)
			begin
				if (count_reg >= FCP_COUNT_LAST)
					count_next = '0;
				else
					count_next = count_reg + 1'b1;
			end
		end
		else
		begin
			div_next = div_reg + 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			div_reg   <= '0;
			half_reg  <= 1'b0;
			count_reg <= '0;
		end
		else
		begin
			div_reg   <= div_next;
			half_reg  <= half_next;
			count_reg <= count_next;
		end
	end

	assign tb.count = count_reg;
endmodule : fcp_timebase

// ===== core/fcp_channel.sv
// one compare channel with enable gating
`timescale 1ns/10ps
module fcp_channel
	import fcp_pkg::*;
	#(parameter int W = FCP_DATA_W)
(
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic [W-1:0] duty,
	input  wire logic         enable,
	input  wire logic         out_en,
	fcp_tb_if.snk             tb,
	output logic              pwm_out,
	output logic              pwm_oe
);
	logic out_reg;
	logic out_next;
	logic oe_reg;
	logic oe_next;

	// duty is compared live, so a new value shows one clock after it is written
	always_comb
	begin
		out_next = enable && out_en && (duty > tb.count);
		oe_next  = out_en;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			out_reg <= 1'b0;
			oe_reg  <= 1'b0;
		end
		else
		begin
			out_reg <= out_next;
			oe_reg  <= oe_next;
		end
	end

	assign pwm_out = out_reg;
	assign pwm_oe  = oe_reg;
endmodule : fcp_channel

// ===== core/fcp_top.sv
// five-channel pwm unit with an ahb-lite register slave
// Contract
// - one shared 8-bit prescaler clocks shared counter
// - counter counts 0 to 254 then wraps
// - output high while duty exceeds counter
// - period is 2 x (prescale+1) x 255 clocks
// - duty FFh gives constant high output
// - new duty value acts immediately
// - each channel has its own enable
// - control two: bit2 output enable, bit0 enable
// - duty ratio steps of 1/255
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/10ps
module fcp_top
	import fcp_pkg::*;
	#(parameter int CH = FCP_CHANNELS)
(
	input  wire logic          hclk,
	input  wire logic          hresetn,
	input  wire logic          hsel,
	input  wire logic [31:0]   haddr,
	input  wire logic [1:0]    htrans,
	input  wire logic          hwrite,
	input  wire logic [2:0]    hsize,
	input  wire logic [31:0]   hwdata,
	input  wire logic          hready,
	output logic      [31:0]   hrdata,
	output logic               hreadyout,
	output logic      [1:0]    hresp,
	output logic      [CH-1:0] pwm_out,
	output logic      [CH-1:0] pwm_oe
);
	logic [7:0]  prescale_reg;
	logic [7:0]  prescale_next;
	logic [7:0]  ctrl_one_reg;
	logic [7:0]  ctrl_one_next;
	logic [7:0]  ctrl_two_reg;
	logic [7:0]  ctrl_two_next;
	logic [7:0]  duty_reg  [CH];
	logic [7:0]  duty_next [CH];
	logic        wr_pend_reg;
	logic        wr_pend_next;
	logic [11:0] wr_addr_reg;
	logic [11:0] wr_addr_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic        take;
	logic [CH-1:0] chan_en;
	logic [CH-1:0] chan_oe;

	fcp_tb_if #(.W(FCP_DATA_W)) tb_bus ();

	// true when a byte address selects duty register n
	function automatic logic is_duty(input logic [11:0] a, input int n);
		is_duty = (a == 12'(FCP_ADDR_DUTY_BASE + 12'(4 * n)));
	endfunction : is_duty

	assign take = hsel && hready && htrans[1];

	// register writes land in the data phase of the transfer
	always_comb
	begin
		wr_pend_next  = take && hwrite;
		wr_addr_next  = take ? haddr[11:0] : wr_addr_reg;
		prescale_next = prescale_reg;
		ctrl_one_next = ctrl_one_reg;
		ctrl_two_next = ctrl_two_reg;
		for (int i = 0; i < CH; i++)
			duty_next[i] = duty_reg[i];
		if (wr_pend_reg)
		begin
			if (wr_addr_reg == FCP_ADDR_PRESCALE)
				prescale_next = hwdata[7:0];
			if (wr_addr_reg == FCP_ADDR_CTRL_ONE)
				ctrl_one_next = hwdata[7:0];
			if (wr_addr_reg == FCP_ADDR_CTRL_TWO)
				ctrl_two_next = hwdata[7:0] & FCP_CTRL_TWO_MASK;
			for (int i = 0; i < CH; i++)
				if (is_duty(wr_addr_reg, i))
					duty_next[i] = hwdata[7:0];
		end
	end

	// read data is taken from the next values so a write just before a read is seen
	always_comb
	begin
		rdata_next = '0;
		if (take && !hwrite)
		begin
			if (haddr[11:0] == FCP_ADDR_PRESCALE)
				rdata_next = {24'h000000, prescale_next};
			if (haddr[11:0] == FCP_ADDR_CTRL_ONE)
				rdata_next = {24'h000000, ctrl_one_next};
			if (haddr[11:0] == FCP_ADDR_CTRL_TWO)
				rdata_next = {24'h000000, ctrl_two_next};
			if (haddr[11:0] == FCP_ADDR_STATUS)
				rdata_next = {24'h000000, tb_bus.count};
			for (int i = 0; i < CH; i++)
				if (is_duty(haddr[11:0], i))
					rdata_next = {24'h000000, duty_next[i]};
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			prescale_reg <= FCP_BYTE_RESET;
			ctrl_one_reg <= FCP_BYTE_RESET;
			ctrl_two_reg <= FCP_BYTE_RESET;
			for (int i = 0; i < CH; i++)
				duty_reg[i] <= FCP_BYTE_RESET;
			wr_pend_reg  <= 1'b0;
			wr_addr_reg  <= 12'h000;
			rdata_reg    <= 32'h00000000;
		end
		else
		begin
			prescale_reg <= prescale_next;
			ctrl_one_reg <= ctrl_one_next;
			ctrl_two_reg <= ctrl_two_next;
			for (int i = 0; i < CH; i++)
				duty_reg[i] <= duty_next[i];
			wr_pend_reg  <= wr_pend_next;
			wr_addr_reg  <= wr_addr_next;
			rdata_reg    <= rdata_next;
		end
	end

	// channels 0..3 use control one, channel 4 uses control two
	always_comb
	begin
		chan_en = '0;
		chan_oe = '0;
		for (int i = 0; i < CH; i++)
		begin
			if (i < FCP_CTRL_ONE_OE_LSB)
			begin
				chan_en[i] = ctrl_one_reg[i];
				chan_oe[i] = ctrl_one_reg[i + FCP_CTRL_ONE_OE_LSB];
			end
			else
			begin
				chan_en[i] = ctrl_two_reg[FCP_CTRL_TWO_EN_BIT];
				chan_oe[i] = ctrl_two_reg[FCP_CTRL_TWO_OE_BIT];
			end
		end
	end

	fcp_timebase #(.W(FCP_DATA_W)) u_timebase
	(
		.hclk     (hclk),
		.hresetn  (hresetn),
		.prescale (prescale_reg),
		.tb       (tb_bus)
	);

	for (genvar g = 0; g < CH; g++)
	begin : g_chan
		fcp_channel #(.W(FCP_DATA_W)) u_chan
		(
			.hclk    (hclk),
			.hresetn (hresetn),
			.duty    (duty_reg[g]),
			.enable  (chan_en[g]),
			.out_en  (chan_oe[g]),
			.tb      (tb_bus),
			.pwm_out (pwm_out[g]),
			.pwm_oe  (pwm_oe[g])
		);
	end

	// zero-wait slave; unmapped addresses read zero and ignore writes
	assign hreadyout = 1'b1;
	assign hresp     = FCP_HRESP_OKAY;
	assign hrdata    = rdata_reg;
endmodule : fcp_top

// ===== bench/fcp_top_chk.sv
// port checker for the pwm unit
`timescale 1ns/10ps
module fcp_top_chk
	import fcp_pkg::*;
	#(parameter int CH = FCP_CHANNELS)
(
	input wire logic          hclk,
	input wire logic          hresetn,
	input wire logic          hsel,
	input wire logic [31:0]   haddr,
	input wire logic [1:0]    htrans,
	input wire logic          hwrite,
	input wire logic          hready,
	input wire logic [31:0]   hrdata,
	input wire logic          hreadyout,
	input wire logic [1:0]    hresp,
	input wire logic [CH-1:0] pwm_out,
	input wire logic [CH-1:0] pwm_oe
);
	logic rd_take;
	assign rd_take = hsel && hready && htrans[1] && !hwrite;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	ready_high_a: assert property (hreadyout) else $error("hreadyout low");
	resp_okay_a: assert property (hresp == FCP_HRESP_OKAY) else $error("hresp bad");
	rst_out_low_a: assert property ($rose(hresetn) |-> pwm_out == '0)
		else $error("out after reset");
	rst_oe_low_a: assert property ($rose(hresetn) |-> pwm_oe == '0)
		else $error("oe after reset");
	// output and its pin enable leave the same register stage, so the output must never be high in a cycle where its enable is low
	oe_gate_a: assert property ((pwm_out & ~pwm_oe) == '0)
		else $error("out without oe");
	rdata_idle_a: assert property (!rd_take |=> hrdata == 32'h0) else $error("hrdata stale");
	ctrl_two_bits_a: assert property (rd_take && haddr[11:0] == FCP_ADDR_CTRL_TWO
		|=> (hrdata & ~32'h5) == 32'h0) else $error("ctrl two bits");
	count_range_a: assert property (rd_take && haddr[11:0] == FCP_ADDR_STATUS
		|=> hrdata < 32'hFF) else $error("count range");
endmodule : fcp_top_chk
bind fcp_top fcp_top_chk #(.CH(CH)) i_fcp_top_chk (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pwm_out(pwm_out),
	.pwm_oe(pwm_oe));

// ===== bench/fcp_load.sv
// motor-driver load: counts the high cycles seen on each output
`timescale 1ns/10ps
module fcp_load
(
	input wire logic        hclk,
	input wire logic        clr,
	input wire logic [4:0]  pwm,
	output logic     [15:0] hi [5]
);
	always_ff @(posedge hclk)
		for (int i = 0; i < 5; i++)
			hi[i] <= clr ? 16'h0 : hi[i] + 16'(pwm[i]);
endmodule : fcp_load

// ===== bench/testbench.sv
// register-level test of the pwm unit
`timescale 1ns/10ps
module testbench;
	import fcp_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, hready, clr;
	logic [31:0] haddr, hwdata, hrdata, v;
	logic [1:0]  htrans, hresp;
	logic [4:0]  pwm_out, pwm_oe;
	logic [15:0] hi [5];
	logic [7:0]  dt [5] = '{8'h00, 8'h01, 8'h20, 8'hFE, 8'hFF};
	int          err_count = 0;
	int          checks = 0;
	fcp_top i_fcp_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .pwm_out(pwm_out),
		.pwm_oe(pwm_oe));
	fcp_load i_fcp_load (.hclk(hclk), .clr(clr), .pwm(pwm_out), .hi(hi));
	initial
	begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	task end_sim;
		if (err_count == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			err_count++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task bus(input logic w, input logic [11:0] a, input logic [7:0] d);
		hsel   <= 1'b1;
		haddr  <= {20'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		v = hrdata;
	endtask : bus
	task meas(input int p, input logic [4:0] m);
		int e;
		repeat (4) @(posedge hclk);
		clr <= 1'b1;
		@(posedge hclk);
		clr <= 1'b0;
		repeat (510 * (p + 1)) @(posedge hclk);
		#1;
		for (int i = 0; i < 5; i++)
		begin
			e = m[i] ? (dt[i] == 8'hFF ? 510 : 2 * dt[i]) * (p + 1) : 0;
			chk("high", e, 32'(hi[i]));
		end
		@(posedge hclk);
	endtask : meas
	initial
	begin
		repeat (20000) @(posedge hclk);
		err_count++;
		end_sim;
	end
	initial
	begin
		{hresetn, hsel, hwrite, clr, htrans, haddr, hwdata} = '0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(0, FCP_ADDR_PRESCALE, 0);
		chk("prescale", 0, v);
		bus(0, FCP_ADDR_CTRL_ONE, 0);
		chk("ctrl_one", 0, v);
		bus(0, FCP_ADDR_DUTY_BASE, 0);
		chk("duty0", 0, v);
		bus(1, FCP_ADDR_CTRL_TWO, 8'hFF);
		bus(0, FCP_ADDR_CTRL_TWO, 0);
		chk("ctrl_two", 32'h5, v);
		bus(0, 12'h100, 0);
		chk("unmapped", 0, v);
		repeat (300)
		begin
			bus(0, FCP_ADDR_STATUS, 0);
			chk("count", 1, v < 32'hFF);
		end
		bus(1, FCP_ADDR_CTRL_ONE, 8'hFF);
		chk("low", 0, pwm_out);
		bus(1, FCP_ADDR_DUTY_BASE, 8'hFF);
		@(posedge hclk);
		#1;
		chk("instant", 1, pwm_out[0]);
		@(posedge hclk);
		for (int i = 0; i < 5; i++)
			bus(1, FCP_ADDR_DUTY_BASE + 12'(4 * i), dt[i]);
		meas(0, 5'h1F);
		bus(1, FCP_ADDR_PRESCALE, 8'h02);
		meas(2, 5'h1F);
		bus(1, FCP_ADDR_CTRL_ONE, 8'hB7);
		@(posedge hclk);
		#1;
		chk("oe", 32'h1B, pwm_oe);
		meas(2, 5'h13);
		// a reset in mid-run with outputs active must clear everything again
		hresetn <= 1'b0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		#1;
		chk("rst_out", 0, pwm_out);
		chk("rst_oe", 0, pwm_oe);
		@(posedge hclk);
		bus(0, FCP_ADDR_PRESCALE, 0);
		chk("rst_prescale", 0, v);
		bus(0, FCP_ADDR_CTRL_ONE, 0);
		chk("rst_ctrl_one", 0, v);
		bus(0, FCP_ADDR_CTRL_TWO, 0);
		chk("rst_ctrl_two", 0, v);
		bus(0, FCP_ADDR_DUTY_BASE + 12'h010, 0);
		chk("rst_duty4", 0, v);
		end_sim;
	end
endmodule : testbench
